// ==== src/pbs_map.svh ====
// Purpose: Constants for the page buffer command and status read link.
// Assumes: SPI mode 0 framing, opcode and address sent MSB first.
// Notes:   Interval counts are in 40 MHz core clock cycles.
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH

`define PBS_OP_XFER      8'h53
`define PBS_OP_COMP      8'h60
`define PBS_OP_REWR      8'h58
`define PBS_OP_STAT      8'hd7
`define PBS_CMD_BITS     6'h20
`define PBS_FRAME_BITS   6'h20
`define PBS_STAT_BITS    6'h10
// Page index field: bits 18:9 for 264-byte pages, 17:8 for 256-byte pages.
`define PBS_PIX264_LSB   9
`define PBS_PIX256_LSB   8
`define PBS_ONE_BUSY_BIT 7
`define PBS_ONE_COMP_BIT 6
`define PBS_TWO_FAIL_BIT 5
`define PBS_TWO_LOCK_BIT 3
// Density code value is arbitrary.
`define PBS_DENSITY      4'ha
`define PBS_XFER_NS      2000
`define PBS_COMP_NS      2000
`define PBS_REWR_NS      20000
`define PBS_CLK_NS       25
`define PBS_XFER_CYC     (`PBS_XFER_NS / `PBS_CLK_NS)
`define PBS_COMP_CYC     (`PBS_COMP_NS / `PBS_CLK_NS)
`define PBS_REWR_CYC     (`PBS_REWR_NS / `PBS_CLK_NS)
`define PBS_HALF_DIV     4'h3

`endif

// ==== src/pbs_pkg.sv ====
// Purpose: Shared types for the page buffer command link.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only.
`default_nettype none
package pbs_pkg;
    typedef enum logic [1:0] {PBS_NONE, PBS_XFER, PBS_COMP, PBS_REWR} pbs_op_t;
endpackage
`default_nettype wire

// ==== src/pbs_link_if.sv ====
// Purpose: Serial pins joining host and memory ends.
// Assumes: Host drives select, clock and data in; memory drives data out.
// Notes:   The resolved out line floats high when not driven.
`default_nettype none
interface pbs_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so_o;
    logic so_oe;
    wire  so = so_oe ? so_o : 1'b1;
    modport mem  (input cs_n, input sck, input si, output so_o, output so_oe);
    modport host (output cs_n, output sck, output si, input so);
endinterface
`default_nettype wire

// ==== src/pbs_mem.sv ====
// Purpose: Memory end: decodes page commands and streams status.
// Assumes: Link pins are asynchronous and pass two flops first.
// Notes:   Array and buffer data path are outside; this block times them.
`include "pbs_map.svh"
`default_nettype none
module pbs_mem (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Link
    pbs_link_if.mem          link,
    // Configuration and array status
    input  wire logic        page256_i,
    input  wire logic        protect_i,
    input  wire logic        lock_cmd_allowed_flag_i,
    input  wire logic        array_fail_i,
    input  wire logic        mismatch_i,
    // Array requests
    output logic             op_start_o,
    output pbs_pkg::pbs_op_t op_kind_o,
    output logic [9:0]       page_index_bits_o,
    output logic             rmw_o,
    output logic             busy_o,
    output logic [7:0]       status_one_o
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] cs_s_q, sck_s_q, si_s_q;
    logic       sck_prev_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_s_q     <= 2'h3;
            sck_s_q    <= 2'h0;
            si_s_q     <= 2'h0;
            sck_prev_q <= 1'b0;
        end else begin
            cs_s_q     <= {cs_s_q[0], link.cs_n};
            sck_s_q    <= {sck_s_q[0], link.sck};
            si_s_q     <= {si_s_q[0], link.si};
            sck_prev_q <= sck_s_q[1];
        end
    end
    wire cs_n_w   = cs_s_q[1];
    wire sck_rise = sck_s_q[1] & ~sck_prev_q & ~cs_n_w;
    wire sck_fall = ~sck_s_q[1] & sck_prev_q & ~cs_n_w;
    logic cs_prev_q;
    wire  cs_rise = cs_n_w & ~cs_prev_q;

    // ****************************************
    // Command shifter
    // ****************************************
    logic [31:0] shift_q;
    logic [5:0]  cnt_q;
    logic        extra_q;
    logic        stat_q;
    logic [3:0]  scnt_q;
    logic [7:0]  sbyte_q;
    wire [7:0]   opc_w   = shift_q[31:24];
    wire         full_w  = (cnt_q == `PBS_FRAME_BITS);
    // The opcode sits in the low byte after eight bits, long before the whole frame is in.
    wire         is_stat = (cnt_q == 6'h8) && (shift_q[7:0] == `PBS_OP_STAT);
    wire [9:0]   pix_w   = page256_i ?
        shift_q[`PBS_PIX256_LSB +: 10] :
        shift_q[`PBS_PIX264_LSB +: 10];
    pbs_pkg::pbs_op_t dec_w;
    assign dec_w = (opc_w == `PBS_OP_XFER) ? pbs_pkg::PBS_XFER :
                   (opc_w == `PBS_OP_COMP) ? pbs_pkg::PBS_COMP :
                   (opc_w == `PBS_OP_REWR) ? pbs_pkg::PBS_REWR :
                   pbs_pkg::PBS_NONE;
    // Operations wait for the end of the frame; a partial frame is dropped.
    wire go_w = cs_rise && full_w && !stat_q && !busy_o &&
                dec_w != pbs_pkg::PBS_NONE;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_prev_q <= 1'b1;
            shift_q   <= 32'h0;
            cnt_q     <= 6'h0;
            extra_q   <= 1'b0;
        end else begin
            cs_prev_q <= cs_n_w;
            if (cs_rise) begin
                cnt_q   <= 6'h0;
                extra_q <= 1'b0;
            end else if (sck_rise && !stat_q) begin
                if (full_w) begin
                    extra_q <= 1'b1;
                end else begin
                    shift_q <= {shift_q[30:0], si_s_q[1]};
                    cnt_q   <= cnt_q + 6'h1;
                end
            end
        end
    end

    // ****************************************
    // Operation timer
    // ****************************************
    logic [9:0] tmr_q;
    logic       cmp_q, fail_q;
    wire [9:0]  dur_w = (dec_w == pbs_pkg::PBS_XFER) ? 10'(`PBS_XFER_CYC) :
                        (dec_w == pbs_pkg::PBS_COMP) ? 10'(`PBS_COMP_CYC) :
                        10'(`PBS_REWR_CYC);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_q             <= 10'h0;
            busy_o            <= 1'b0;
            op_start_o        <= 1'b0;
            op_kind_o         <= pbs_pkg::PBS_NONE;
            page_index_bits_o <= 10'h0;
            rmw_o             <= 1'b0;
            cmp_q             <= 1'b0;
            fail_q            <= 1'b0;
        end else begin
            op_start_o <= go_w;
            if (go_w) begin
                busy_o            <= 1'b1;
                tmr_q             <= dur_w;
                op_kind_o         <= dec_w;
                page_index_bits_o <= pix_w;
                rmw_o             <= extra_q &&
                                     dec_w == pbs_pkg::PBS_REWR;
            end else if (busy_o) begin
                if (tmr_q == 10'h1) begin
                    busy_o <= 1'b0;
                    if (op_kind_o == pbs_pkg::PBS_COMP)
                        cmp_q <= mismatch_i;
                    if (op_kind_o == pbs_pkg::PBS_REWR)
                        fail_q <= array_fail_i;
                end
                tmr_q <= tmr_q - 10'h1;
            end
        end
    end

    // ****************************************
    // Status stream
    // ****************************************
    wire [7:0] one_w = {~busy_o, cmp_q, `PBS_DENSITY,
                        protect_i, page256_i};
    wire [7:0] two_w = {~busy_o, 1'b0, fail_q, 1'b0,
                        lock_cmd_allowed_flag_i, 3'h0};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q       <= 1'b0;
            scnt_q       <= 4'h0;
            sbyte_q      <= 8'h0;
            link.so_o    <= 1'b0;
            link.so_oe   <= 1'b0;
            status_one_o <= 8'h0;
        end else begin
            status_one_o <= one_w;
            if (cs_rise) begin
                stat_q     <= 1'b0;
                link.so_oe <= 1'b0;
            end else if (is_stat && !stat_q) begin
                stat_q  <= 1'b1;
                scnt_q  <= 4'h0;
                sbyte_q <= one_w;
            end else if (stat_q && sck_fall) begin
                // Each byte reloads fresh at its boundary.
                link.so_oe <= 1'b1;
                link.so_o  <= (scnt_q[2:0] == 3'h0) ?
                              ~busy_o : sbyte_q[6];
                sbyte_q    <= (scnt_q[2:0] == 3'h0) ?
                              (scnt_q[3] ? two_w : one_w) :
                              {sbyte_q[6:0], 1'b0};
                scnt_q     <= scnt_q + 4'h1;
            end
        end
    end
endmodule // pbs_mem
`default_nettype wire

// ==== src/pbs_host.sv ====
// Purpose: Host end: issues page commands and reads status.
// Assumes: Makes the link clock by dividing the core clock.
// Notes:   One command per request; status read ends on stop_i.
`include "pbs_map.svh"
`default_nettype none
module pbs_host (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Link
    pbs_link_if.host         link,
    // User requests
    input  wire logic        req_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [23:0] addr_i,
    input  wire logic        stop_i,
    // User answers
    output logic             done_o,
    output logic [15:0]      status_o,
    output logic             status_vld_o
);
    // ****************************************
    // Frame engine
    // ****************************************
    logic [31:0] sh_q;
    logic [5:0]  n_q;
    logic [3:0]  div_q;
    logic        act_q, stat_q;
    logic [15:0] rx_q;
    logic [1:0]  so_s_q;
    wire tick   = (div_q == `PBS_HALF_DIV);
    wire last_w = !stat_q && n_q == `PBS_CMD_BITS;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.cs_n    <= 1'b1;
            link.sck     <= 1'b0;
            link.si      <= 1'b0;
            sh_q         <= 32'h0;
            n_q          <= 6'h0;
            div_q        <= 4'h0;
            act_q        <= 1'b0;
            stat_q       <= 1'b0;
            rx_q         <= 16'h0;
            so_s_q       <= 2'h0;
            done_o       <= 1'b0;
            status_o     <= 16'h0;
            status_vld_o <= 1'b0;
        end else begin
            so_s_q       <= {so_s_q[0], link.so};
            done_o       <= 1'b0;
            status_vld_o <= 1'b0;
            div_q        <= tick ? 4'h0 : div_q + 4'h1;
            if (!act_q) begin
                if (req_i) begin
                    act_q     <= 1'b1;
                    stat_q    <= (opcode_i == `PBS_OP_STAT);
                    sh_q      <= {opcode_i, addr_i};
                    n_q       <= 6'h0;
                    link.cs_n <= 1'b0;
                    link.si   <= opcode_i[7];
                end
            end else if (tick) begin
                if (!link.sck) begin
                    if (last_w || (stat_q && stop_i)) begin
                        link.cs_n <= 1'b1;
                        act_q     <= 1'b0;
                        done_o    <= 1'b1;
                    end else begin
                        link.sck <= 1'b1;
                    end
                end else begin
                    link.sck <= 1'b0;
                    sh_q     <= {sh_q[30:0], 1'b0};
                    link.si  <= sh_q[30];
                    n_q      <= (n_q == 6'h3f) ? n_q : n_q + 6'h1;
                    if (stat_q && n_q >= 6'h8) begin
                        rx_q <= {rx_q[14:0], so_s_q[1]};
                        if (n_q[3:0] == 4'h7) begin
                            status_o     <= {rx_q[14:0], so_s_q[1]};
                            status_vld_o <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule // pbs_host
`default_nettype wire

// ==== verif/pbs_link_sva.sv ====
// Purpose: Link checks between the host and memory ends.
// Assumes: Mode 0 framing, four core cycles per half period.
// Notes:   Sees link signals only; status values are judged by the bench.
`include "pbs_map.svh"
`default_nettype none
module pbs_link_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_o,
    input wire logic so_oe
);
    // ******
    // Frame tracking
    // ******
    logic       cs_q;
    logic       sck_q;
    logic [5:0] bits_q;
    logic [7:0] op_q;
    wire        go     = cs_q & ~cs_n;
    wire        bit_in = sck & ~sck_q & ~cs_n;
    // Saturating, so a long status read cannot wrap into a false count.
    always_ff @(posedge clk_i) begin
        cs_q <= rst_i | cs_n;
        sck_q <= sck;
        if (go) bits_q <= 6'h00;
        else if (bit_in && bits_q != 6'h3f) bits_q <= bits_q + 6'h01;
        if (bit_in && bits_q < 6'h08) op_q <= {op_q[6:0], si};
    end
    // ******
    // Properties
    // ******
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_stat_op;
        !cs_n && bits_q == 6'h08 && op_q == `PBS_OP_STAT;
    endsequence
    a_stat_drive: assert property (s_stat_op |-> ##[1:12] so_oe)
        else $error("status not driven after opcode");
    a_oe_cause: assert property (so_oe |-> op_q == `PBS_OP_STAT)
        else $error("out driven without status opcode");
    a_so_release: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
        else $error("out not released after deselect");
    a_idle_float: assert property (cs_n [*6] |-> !so_oe)
        else $error("out driven while deselected");
    a_frame_len: assert property ($rose(cs_n) && op_q != `PBS_OP_STAT
        |-> bits_q == 6'h20)
        else $error("command frame not 32 bits");
    a_sck_half: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("clock high phase wrong");
    a_sck_idle: assert property (cs_n && $past(cs_n) |-> !sck)
        else $error("clock toggles while deselected");
    a_si_steady: assert property ($rose(sck) |=> $stable(si) [*3])
        else $error("data in moved while clock high");
    a_so_steady: assert property ($rose(sck) && so_oe
        |=> $stable(so_o) [*3])
        else $error("data out moved while clock high");
endmodule // pbs_link_sva
`default_nettype wire

// ==== verif/page_buffer_ops_and_status_read_tb.sv ====
// Purpose: Runs both link ends against a queue model of the memory end.
// Assumes: Interval counts and density code of the constants header.
// Notes:   Page and dummy address bits are random from a fixed seed.
`include "pbs_map.svh"
`default_nettype none
module page_buffer_ops_and_status_read_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {pbs_pkg::pbs_op_t k; logic [9:0] pg; int len;} pbs_exp_t;
    logic clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, stop_i = 1'b0;
    logic p256 = 1'b0, prot = 1'b0, lock = 1'b0, fail = 1'b0, mis = 1'b0;
    logic [7:0] opcode_i = 8'h00;
    logic [23:0] addr_i = 24'h000000;
    logic start, rmw, busy, done, vld, comp_m = 1'b0, fail_m = 1'b0;
    pbs_pkg::pbs_op_t kind;
    logic [9:0] pg_ix;
    logic [7:0] st_one;
    logic [15:0] status;
    pbs_exp_t exp_q[$];
    pbs_exp_t cur;
    int bcnt = 0, err_total = 0, num_checks = 0;
    pbs_link_if link ();
    pbs_mem i_pbs_mem (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .page256_i(p256), .protect_i(prot), .lock_cmd_allowed_flag_i(lock),
        .array_fail_i(fail), .mismatch_i(mis), .op_start_o(start),
        .op_kind_o(kind), .page_index_bits_o(pg_ix), .rmw_o(rmw),
        .busy_o(busy), .status_one_o(st_one));
    pbs_host i_pbs_host (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .req_i(req_i), .opcode_i(opcode_i), .addr_i(addr_i), .stop_i(stop_i),
        .done_o(done), .status_o(status), .status_vld_o(vld));
    pbs_link_sva i_pbs_link_sva (.clk_i(clk_i), .rst_i(rst_i),
        .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so_o(link.so_o),
        .so_oe(link.so_oe));
    initial forever #12.5 clk_i = ~clk_i;
    // ******
    // Model and checks
    // ******
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (start === 1'b1 && exp_q.size() == 0) check(16'h1, 16'h0);
        else if (start === 1'b1) begin
            cur = exp_q.pop_front();
            check({3'h0, rmw, kind, pg_ix},
                  {4'h0, cur.k, cur.pg});
        end
        if (busy === 1'b1) bcnt++;
        else if (bcnt != 0) begin
            check(16'(bcnt), 16'(cur.len));
            if (cur.k == pbs_pkg::PBS_COMP) comp_m = mis;
            if (cur.k == pbs_pkg::PBS_REWR) fail_m = fail;
            bcnt = 0;
        end
    end
    task automatic wait_sig(input int sel, input int lim);
        int n = 0;
        logic hit = 1'b0;
        while (!hit && n < lim) begin
            @(posedge clk_i);
            hit = (sel == 0 ? done : (sel == 1 ? vld : ~busy)) === 1'b1;
            n++;
        end
        if (!hit) check(16'h1, 16'h0);
    endtask
    task automatic run_op(input logic [7:0] op, input pbs_pkg::pbs_op_t k,
                          input int len);
        logic [9:0] pg;
        logic [23:0] ad;
        pg = 10'($urandom);
        ad = 24'($urandom);
        if (p256) ad[17:8] = pg;
        else ad[18:9] = pg;
        if (k != pbs_pkg::PBS_NONE) exp_q.push_back('{k, pg, len});
        @(posedge clk_i);
        {opcode_i, addr_i, req_i} <= {op, ad, 1'b1};
        @(posedge clk_i);
        req_i <= 1'b0;
        if (op != `PBS_OP_STAT) wait_sig(0, 3000);
    endtask
    task automatic wait_idle();
        // Busy lags the select rise by the synchroniser, so let it show.
        repeat (20) @(posedge clk_i);
        wait_sig(2, 1000);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic stat_rd(input logic bsy);
        logic [15:0] ex;
        ex = {~bsy, comp_m, `PBS_DENSITY, prot, p256,
              ~bsy, 1'b0, fail_m, 1'b0, lock, 3'h0};
        run_op(`PBS_OP_STAT, pbs_pkg::PBS_NONE, 0);
        repeat (2) begin
            wait_sig(1, 400);
            check(status, ex);
        end
        check({8'h00, st_one}, {8'h00, ex[15:8]});
        stop_i <= 1'b1;
        wait_sig(0, 400);
        stop_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check({14'h0, link.so_oe, link.so}, 16'h1);
    endtask
    // ******
    // Tests
    // ******
    initial begin
        void'($urandom(32'hc4c8));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int m = 0; m < 2; m++) begin
            {p256, prot, lock, fail} <= {m[0], ~m[0], ~m[0], ~m[0]};
            @(posedge clk_i);
            stat_rd(1'b0);
            run_op(`PBS_OP_XFER, pbs_pkg::PBS_XFER, `PBS_XFER_CYC);
            wait_idle();
            for (int c = 0; c < 2; c++) begin
                mis <= ~c[0];
                run_op(`PBS_OP_COMP, pbs_pkg::PBS_COMP, `PBS_COMP_CYC);
                wait_idle();
                stat_rd(1'b0);
            end
            $display("Test transfer and compare ended");
            run_op(`PBS_OP_REWR, pbs_pkg::PBS_REWR, `PBS_REWR_CYC);
            repeat (20) @(posedge clk_i);
            // A command landing while busy must be dropped, not queued.
            stat_rd(1'b1);
            run_op(`PBS_OP_XFER, pbs_pkg::PBS_NONE, 0);
            wait_idle();
            run_op(8'h00, pbs_pkg::PBS_NONE, 0);
            wait_idle();
            stat_rd(1'b0);
            $display("Test rewrite and refusal ended");
        end
        end_sim();
    end
    initial begin
        #600000;
        err_total++;
        end_sim();
    end
endmodule // page_buffer_ops_and_status_read_tb
`default_nettype wire
